// ### cfg_pkg.sv
// Purpose: shared constants for the serial configuration slave of the clock buffer
// Assumes: one system clock, serial link pins sampled asynchronously
// Notes: register image bits and write masks live here; the bench repeats them as literals
package cfg_pkg;
   // ****************************************
   // link framing
   // ****************************************
   localparam logic [6:0] SLAVE_ADDR = 7'h6E;
   localparam logic [2:0] BYTE_OP_PAT = 3'h4;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int SYNC_STAGES = 2;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [6:0] IDX_DRIVE_PLL = 7'h00;
   localparam logic [6:0] IDX_PAIR_EN = 7'h01;
   localparam logic [7:0] RST_DRIVE_PLL = 8'h07;
   localparam logic [7:0] RST_PAIR_EN = 8'hFF;
   localparam logic [7:0] WMASK_DRIVE_PLL = 8'hC7;
   localparam logic [7:0] WMASK_PAIR_EN = 8'h66;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int PD_TRI_BIT = 7;
   localparam int STOP_TRI_BIT = 6;
   localparam int BW_BIT = 2;
   localparam int PLL_BIT = 1;
   localparam int HALF_BIT = 0;
   localparam int NUM_PAIRS = 4;
   localparam int PAIR_BIT [NUM_PAIRS] = '{1, 2, 5, 6};
endpackage

// ### pin_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are slow levels relative to the clock
// Notes: only the second stage is visible outside
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;

   sync_s r;
   sync_s n;

   always_comb begin
      n = r;
      n.meta = pin_i;
      n.stable = r.meta;
   end

   // idle bus level is high, so reset to ones to avoid a false start
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '1;
      end else begin
         r <= n;
      end
   end

   assign sync_o = r.stable;
endmodule

// ### cfg_regs.sv
// Purpose: the two control registers and their decoded fields
// Assumes: write strobe is one clock wide and comes from the same clock
// Notes: unmapped indexes read as zero and swallow writes
`timescale 1ns/1ns
module cfg_regs (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wr_i,
   input wire logic [6:0] idx_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic pd_tristate_o,
   output logic stop_tristate_o,
   output logic bandwidth_select_n_o,
   output logic pll_mode_o,
   output logic half_rate_select_n_o,
   output logic [cfg_pkg::NUM_PAIRS-1:0] pair_enable_o
);
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] pair;
   } regs_s;

   regs_s r;
   regs_s n;

   always_comb begin
      n = r;
      if (wr_i && idx_i == cfg_pkg::IDX_DRIVE_PLL) begin
         n.ctl = (wdata_i & cfg_pkg::WMASK_DRIVE_PLL) |
                 (cfg_pkg::RST_DRIVE_PLL & ~cfg_pkg::WMASK_DRIVE_PLL);
      end
      if (wr_i && idx_i == cfg_pkg::IDX_PAIR_EN) begin
         n.pair = (wdata_i & cfg_pkg::WMASK_PAIR_EN) |
                  (cfg_pkg::RST_PAIR_EN & ~cfg_pkg::WMASK_PAIR_EN);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r.ctl <= cfg_pkg::RST_DRIVE_PLL;
         r.pair <= cfg_pkg::RST_PAIR_EN;
      end else begin
         r <= n;
      end
   end

   always_comb begin
      case (idx_i)
         cfg_pkg::IDX_DRIVE_PLL: rdata_o = r.ctl;
         cfg_pkg::IDX_PAIR_EN: rdata_o = r.pair;
         default: rdata_o = cfg_pkg::UNMAPPED_READ;
      endcase
   end

   assign pd_tristate_o = r.ctl[cfg_pkg::PD_TRI_BIT];
   assign stop_tristate_o = r.ctl[cfg_pkg::STOP_TRI_BIT];
   assign bandwidth_select_n_o = r.ctl[cfg_pkg::BW_BIT];
   assign pll_mode_o = r.ctl[cfg_pkg::PLL_BIT];
   assign half_rate_select_n_o = r.ctl[cfg_pkg::HALF_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < cfg_pkg::NUM_PAIRS; gi++) begin : g_pair
         assign pair_enable_o[gi] = r.pair[cfg_pkg::PAIR_BIT[gi]];
      end
   endgenerate

   // ****************************************
   // checks
   // ****************************************
   a_reserved_fixed: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ((r.ctl & ~cfg_pkg::WMASK_DRIVE_PLL) == (cfg_pkg::RST_DRIVE_PLL & ~cfg_pkg::WMASK_DRIVE_PLL))
      && ((r.pair & ~cfg_pkg::WMASK_PAIR_EN) == (cfg_pkg::RST_PAIR_EN & ~cfg_pkg::WMASK_PAIR_EN)))
      else $error("reserved register bits changed");

   a_mode_write: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (wr_i && idx_i == cfg_pkg::IDX_DRIVE_PLL) |=>
      ({pd_tristate_o, stop_tristate_o, bandwidth_select_n_o, pll_mode_o, half_rate_select_n_o}
       == {$past(wdata_i[7:6]), $past(wdata_i[2:0])}))
      else $error("mode fields did not follow the write");

   a_pair_write: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (wr_i && idx_i == cfg_pkg::IDX_PAIR_EN) |=>
      (pair_enable_o == {$past(wdata_i[6:5]), $past(wdata_i[2:1])}))
      else $error("pair enables did not follow the write");

   a_idle_hold: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !wr_i |=> $stable(r))
      else $error("registers changed without a write");
endmodule

// ### smbus_buffer_config_regs.sv
// Purpose: serial slave giving byte read and byte write to the control registers
// Assumes: link clock far slower than MCLK_I, pins sampled through two flops
// Notes: block transfers are refused by leaving the command unacknowledged
`timescale 1ns/1ns
module smbus_buffer_config_regs (
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N_O,
   output logic PD_TRISTATE_O,
   output logic STOP_TRISTATE_O,
   output logic BANDWIDTH_SELECT_N_O,
   output logic PLL_MODE_O,
   output logic HALF_RATE_SELECT_N_O,
   output logic [cfg_pkg::NUM_PAIRS-1:0] PAIR_ENABLE_O
);
   // ****************************************
   // types and state
   // ****************************************
   typedef enum logic [3:0] {
      IDLE,
      ADDR,
      ADDR_ACK,
      CMD,
      CMD_ACK,
      WDATA,
      WDATA_ACK,
      RDATA,
      RDATA_ACK,
      IGNORE
   } phase_e;

   typedef struct packed {
      phase_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [6:0] idx;
      logic rw;
      logic drv;
      logic wr;
      logic scl_prev;
      logic sda_prev;
   } slave_s;

   localparam slave_s RST_S = '{st: IDLE, scl_prev: 1'b1, sda_prev: 1'b1, default: '0};

   slave_s r;
   slave_s n;

   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic [7:0] rd_data;

   // ****************************************
   // pin sampling and bus events
   // ****************************************
   pin_sync #(
      .W(cfg_pkg::SYNC_STAGES)
   ) u_sync (
      .clk_i(MCLK_I),
      .resetn_i(RESETN_I),
      .pin_i({SCL_I, SDA_I}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   assign scl_rise = scl_s & ~r.scl_prev;
   assign scl_fall = ~scl_s & r.scl_prev;
   // sda edges only count while scl stays high on both samples
   assign start_ev = scl_s & r.scl_prev & r.sda_prev & ~sda_s;
   assign stop_ev = scl_s & r.scl_prev & ~r.sda_prev & sda_s;

   // ****************************************
   // transfer sequencer
   // ****************************************
   always_comb begin
      n = r;
      n.wr = 1'b0;
      n.scl_prev = scl_s;
      n.sda_prev = sda_s;
      if (start_ev) begin
         // repeated start keeps the index for the read that follows
         n.st = ADDR;
         n.cnt = '0;
         n.drv = 1'b0;
      end else if (stop_ev) begin
         n.st = IDLE;
         n.cnt = '0;
         n.drv = 1'b0;
      end else begin
         case (r.st)
            IDLE, IGNORE: begin
               n.drv = 1'b0;
            end
            ADDR, CMD, WDATA: begin
               if (scl_rise) begin
                  n.sh = {r.sh[6:0], sda_s};
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt == cfg_pkg::LAST_BIT) begin
                     n.cnt = '0;
                     if (r.st == ADDR) begin
                        if (r.sh[6:0] == cfg_pkg::SLAVE_ADDR) begin
                           n.rw = sda_s;
                           n.st = ADDR_ACK;
                        end else begin
                           n.st = IGNORE;
                        end
                     end else if (r.st == CMD) begin
                        if (r.sh[6:4] == cfg_pkg::BYTE_OP_PAT) begin
                           n.idx = {r.sh[5:0], sda_s};
                           n.st = CMD_ACK;
                        end else begin
                           n.st = IGNORE;
                        end
                     end else begin
                        n.wr = 1'b1;
                        n.st = WDATA_ACK;
                     end
                  end
               end
            end
            ADDR_ACK, CMD_ACK, WDATA_ACK: begin
               // first fall pulls sda low, second fall releases it, or after a read address drives the first read bit
               if (scl_fall) begin
                  if (!r.drv) begin
                     n.drv = 1'b1;
                  end else begin
                     n.drv = 1'b0;
                     if (r.st == ADDR_ACK && r.rw) begin
                        n.st = RDATA;
                        n.sh = rd_data;
                        n.drv = ~rd_data[7];
                        n.cnt = '0;
                     end else if (r.st == ADDR_ACK) begin
                        n.st = CMD;
                     end else if (r.st == CMD_ACK) begin
                        n.st = WDATA;
                     end else begin
                        // only one data byte per write is taken
                        n.st = IGNORE;
                     end
                  end
               end
            end
            RDATA: begin
               if (scl_rise) begin
                  n.cnt = r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r.cnt == cfg_pkg::BITS_PER_BYTE) begin
                     n.drv = 1'b0;
                     n.st = RDATA_ACK;
                  end else begin
                     n.sh = {r.sh[6:0], 1'b0};
                     n.drv = ~r.sh[6];
                  end
               end
            end
            RDATA_ACK: begin
               // host ack or nak alike ends the single byte read
               if (scl_rise) begin
                  n.st = IGNORE;
               end
            end
            default: begin
               n = RST_S;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         r <= RST_S;
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // registers and pins
   // ****************************************
   cfg_regs u_regs (
      .clk_i(MCLK_I),
      .resetn_i(RESETN_I),
      .wr_i(r.wr),
      .idx_i(r.idx),
      .wdata_i(r.sh),
      .rdata_o(rd_data),
      .pd_tristate_o(PD_TRISTATE_O),
      .stop_tristate_o(STOP_TRISTATE_O),
      .bandwidth_select_n_o(BANDWIDTH_SELECT_N_O),
      .pll_mode_o(PLL_MODE_O),
      .half_rate_select_n_o(HALF_RATE_SELECT_N_O),
      .pair_enable_o(PAIR_ENABLE_O)
   );

   // open drain: only ever pull low
   assign SDA_O = 1'b0;
   assign SDA_OE_N_O = ~r.drv;

   // ****************************************
   // checks
   // ****************************************
   a_start_to_addr: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      start_ev |=> (r.st == ADDR && r.cnt == 4'h0 && !r.drv))
      else $error("start did not restart address phase");

   a_stop_to_idle: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      stop_ev |=> (r.st == IDLE && SDA_OE_N_O))
      else $error("stop did not release the bus");

   a_foreign_addr: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == ADDR && scl_rise && r.cnt == cfg_pkg::LAST_BIT && !start_ev && !stop_ev
       && r.sh[6:0] != cfg_pkg::SLAVE_ADDR) |=> (r.st == IGNORE))
      else $error("foreign address was not ignored");

   a_cmd_decode: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == CMD && scl_rise && r.cnt == cfg_pkg::LAST_BIT && !start_ev && !stop_ev
       && r.sh[6:4] == cfg_pkg::BYTE_OP_PAT)
      |=> (r.st == CMD_ACK && r.idx == $past({r.sh[5:0], sda_s})))
      else $error("byte command index not captured");

   a_read_load: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == ADDR_ACK && r.rw && r.drv && scl_fall && !start_ev && !stop_ev)
      |=> (r.st == RDATA && r.sh == $past(rd_data) && r.drv == ~$past(rd_data[7])))
      else $error("read byte not loaded for transmit");

   a_ignore_quiet: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == IGNORE || r.st == IDLE) |-> SDA_OE_N_O)
      else $error("sda pulled while not addressed");

   a_write_strobe: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      r.wr |-> (r.st == WDATA_ACK && !r.drv) ##1 !r.wr)
      else $error("write strobe out of place");

   // ****************************************
   // byte sequencing checks
   // ****************************************
   a_addr_match: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == ADDR && scl_rise && r.cnt == cfg_pkg::LAST_BIT && !start_ev && !stop_ev
       && r.sh[6:0] == cfg_pkg::SLAVE_ADDR) |=> (r.st == ADDR_ACK && r.rw == $past(sda_s)))
      else $error("own address was not taken");

   a_ack_pull: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      ((r.st == ADDR_ACK || r.st == CMD_ACK || r.st == WDATA_ACK) && !r.drv && scl_fall
       && !start_ev && !stop_ev) |=> !SDA_OE_N_O)
      else $error("acknowledge not driven");

   a_cmd_refuse: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == CMD && scl_rise && r.cnt == cfg_pkg::LAST_BIT && !start_ev && !stop_ev
       && r.sh[6:4] != cfg_pkg::BYTE_OP_PAT) |=> (r.st == IGNORE && SDA_OE_N_O))
      else $error("non byte command was not refused");

   a_data_capture: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == WDATA && scl_rise && r.cnt == cfg_pkg::LAST_BIT && !start_ev && !stop_ev)
      |=> (r.wr && r.sh == $past({r.sh[6:0], sda_s})))
      else $error("write data byte not captured");

   a_read_release: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == RDATA && scl_fall && r.cnt == cfg_pkg::BITS_PER_BYTE && !start_ev && !stop_ev)
      |=> (r.st == RDATA_ACK && SDA_OE_N_O))
      else $error("sda not released for host ack");

   a_read_shift: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == RDATA && scl_fall && r.cnt != cfg_pkg::BITS_PER_BYTE && !start_ev && !stop_ev)
      |=> (r.drv == ~$past(r.sh[6])))
      else $error("read bit not shifted out in order");

   a_one_data_byte: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == WDATA_ACK && r.drv && scl_fall && !start_ev && !stop_ev)
      |=> (r.st == IGNORE && SDA_OE_N_O))
      else $error("second data byte would be taken");

   a_host_ack_end: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      (r.st == RDATA_ACK && scl_rise && !start_ev && !stop_ev)
      |=> (r.st == IGNORE && SDA_OE_N_O))
      else $error("read did not end after host ack");

   a_index_hold: assert property (
      @(posedge MCLK_I) disable iff (!RESETN_I)
      !(r.st == CMD && scl_rise && r.cnt == cfg_pkg::LAST_BIT)
      |=> $stable(r.idx))
      else $error("index changed outside a command byte");
endmodule

// ### smbus_host_model.sv
// Purpose: bit-level host for the serial configuration link
// Assumes: data line has a pull-up; clk_i is the bench clock
// Notes: link period 8 clocks (160 ns); clock stands high between frames
`timescale 1ns/1ns
module smbus_host_model (
   input wire logic clk_i,
   input wire logic dev_sda_i,
   input wire logic dev_sda_oe_n_i,
   output logic scl_o,
   output logic sda_o
);
   logic sda_drv;
   // ****************************************
   // wired-and line
   // ****************************************
   // a released line floats to the pull-up level
   assign sda_o = sda_drv & (dev_sda_oe_n_i | dev_sda_i);
   initial begin
      scl_o = 1'b1;
      sda_drv = 1'b1;
   end
   // ****************************************
   // bit and frame tasks
   // ****************************************
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // data moves mid-low so it never changes beside a clock edge
   task automatic put_bit(input logic b, output logic seen);
      wt(2);
      sda_drv = b;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      seen = sda_o;
      scl_o = 1'b0;
   endtask
   task automatic start();
      wt(2);
      sda_drv = 1'b1;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      sda_drv = 1'b0;
      wt(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      wt(2);
      sda_drv = 1'b0;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      sda_drv = 1'b1;
      wt(4);
   endtask
   // returns the line at the ack slot: 0 means acknowledged
   task automatic send_byte(input logic [7:0] v, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i], s);
      end
      put_bit(1'b1, nak);
   endtask
   task automatic recv_byte(output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, v[i]);
      end
      put_bit(1'b0, s);
   endtask
   // nak = {address, command, data}
   task automatic wr(input logic [7:0] adr, cmd, dat, output logic [2:0] nak);
      start();
      send_byte(adr, nak[2]);
      send_byte(cmd, nak[1]);
      send_byte(dat, nak[0]);
      stop();
   endtask
   // nak = {address, command, read address}; host acks the byte
   task automatic rd(input logic [7:0] adr, cmd, output logic [7:0] dat,
                     output logic [2:0] nak);
      start();
      send_byte(adr, nak[2]);
      send_byte(cmd, nak[1]);
      start();
      send_byte(adr | 8'h01, nak[0]);
      recv_byte(dat);
      stop();
   endtask
endmodule

// ### smbus_buffer_config_regs_tb.sv
// Purpose: self-checking bench for the serial configuration slave
// Assumes: host model drives the link; outputs settle before stop ends
// Notes: register images tracked here with reserved bits fixed
`timescale 1ns/1ns
module smbus_buffer_config_regs_tb;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic scl, sda, sda_out, sda_oe_n, pd, stp, bw, pll, half;
   logic [cfg_pkg::NUM_PAIRS-1:0] pairs;
   logic [7:0] im0, im1, rv;
   logic [2:0] nk;
   int bad_count = 0;
   int cmp_count = 0;
   logic [7:0] tbl [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
   logic [7:0] bad_adr [3] = '{8'hD8, 8'h5C, 8'hDE};
   logic [7:0] bad_cmd [3] = '{8'h00, 8'hA1, 8'hC0};
   always #10 mclk = ~mclk;
   smbus_host_model host (.clk_i(mclk), .dev_sda_i(sda_out),
      .dev_sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
   smbus_buffer_config_regs uut (.MCLK_I(mclk), .RESETN_I(resetn), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_out), .SDA_OE_N_O(sda_oe_n), .PD_TRISTATE_O(pd),
      .STOP_TRISTATE_O(stp), .BANDWIDTH_SELECT_N_O(bw), .PLL_MODE_O(pll),
      .HALF_RATE_SELECT_N_O(half), .PAIR_ENABLE_O(pairs));
   // ****************************************
   // checks and access tasks
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_out();
      logic [3:0] p;
      for (int i = 0; i < 4; i++) begin
         p[i] = im1[cfg_pkg::PAIR_BIT[i]];
      end
      chk("reg0 pins", im0 & 8'hC7, {pd, stp, 3'b000, bw, pll, half});
      chk("pair pins", {4'h0, p}, {4'h0, pairs});
   endtask
   task automatic wreg(input logic [7:0] cmd, dat, input logic [2:0] enk);
      host.wr(8'hDC, cmd, dat, nk);
      chk("write acks", {5'h00, enk}, {5'h00, nk});
   endtask
   task automatic rreg(input logic [7:0] cmd, e);
      host.rd(8'hDC, cmd, rv, nk);
      chk("read acks", 8'h00, {5'h00, nk});
      chk("read data", e, rv);
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      resetn = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      im0 = 8'h07;
      im1 = 8'hFF;
      chk_out();
      rreg(8'h80, im0);
      rreg(8'h81, im1);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      #1000000;
      bad_count++;
      give_verdict();
   end
   initial begin
      do_reset();
      $display("test defaults done");
      // back-to-back writes to both registers, then read back
      for (int i = 0; i < 4; i++) begin
         wreg(8'h80, tbl[i], 3'b000);
         wreg(8'h81, ~tbl[i], 3'b000);
         im0 = tbl[i] & 8'hC7;
         im1 = (~tbl[i] & 8'h66) | 8'h99;
         chk_out();
         rreg(8'h80, im0);
         rreg(8'h81, im1);
      end
      $display("test write readback done");
      // foreign addresses are ignored whole
      for (int i = 0; i < 3; i++) begin
         host.wr(bad_adr[i], 8'h80, 8'hC0, nk);
         chk("foreign acks", 8'h07, {5'h00, nk});
      end
      chk_out();
      $display("test foreign address done");
      // non-byte commands refused after the address ack
      for (int i = 0; i < 3; i++) begin
         wreg(bad_cmd[i], 8'h00, 3'b011);
      end
      chk_out();
      rreg(8'h80, im0);
      $display("test refused command done");
      // unmapped index: write acked but swallowed, read as zero
      wreg(8'h9F, 8'hFF, 3'b000);
      wreg(8'h85, 8'h00, 3'b000);
      rreg(8'h85, 8'h00);
      chk_out();
      rreg(8'h81, im1);
      $display("test unmapped index done");
      do_reset();
      $display("test second reset done");
      give_verdict();
   end
endmodule
